// ---- hdl/dotc_dev.sv ----
`timescale 1ns/1ps
module dotc_dev
  import dotc_pkg::*;
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  dotc_if.dev             LINK,
  input  wire logic       BANKS_IDLE_I,
  input  wire logic       DQ_DRIVE_I,
  output logic            RTT_EN_O,
  output logic            RTT_WR_SEL_O,
  output logic [2:0]      RTT_NOM_O,
  output logic [1:0]      RTT_WR_O,
  output logic            ASYNC_MODE_O
);

  // ***********************************************
  // Declarations
  // ***********************************************
  logic [15:0]           mr0_r;
  logic [15:0]           mr1_r;
  logic [15:0]           mr2_r;
  logic [PIPE_DEPTH-1:0] odt_pipe_r;
  logic [PIPE_DEPTH-1:0] wr_pipe_r;
  logic [PIPE_DEPTH-1:0] bc4_pipe_r;
  logic [ASYNC_CYC-1:0]  odt_async_r;
  logic [2:0]            wr_cnt_r;
  logic [2:0]            wr_cnt_nxt;
  logic                  wr_sel_nxt;
  logic                  pd_r;
  logic                  sref_r;
  logic [4:0]            odtl;
  logic [2:0]            nom_bits;
  logic [1:0]            wr_bits;
  logic                  odt_enabled;
  logic                  dyn_enabled;
  logic                  dll_frozen;
  logic                  async_mode;
  logic                  odt_sync_tap;
  logic                  wr_tap;
  logic                  bc4_tap;
  logic                  rtt_raw;
  logic                  rtt_en_nxt;

  // ***********************************************
  // Mode registers
  // ***********************************************
  // Cleared fields at reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      mr0_r <= MR_RST;
      mr1_r <= MR_RST;
      mr2_r <= MR_RST;
    end else if (LINK.mrs) begin
      case (LINK.mr_sel)
        MR0_SEL: mr0_r <= LINK.mr_data;
        MR1_SEL: mr1_r <= LINK.mr_data;
        MR2_SEL: mr2_r <= LINK.mr_data;
        default: mr0_r <= mr0_r;
      endcase
    end
  end

  // ***********************************************
  // Field decode
  // ***********************************************
  // Strength fields
  assign nom_bits = {mr1_r[MR1_NOM_B2], mr1_r[MR1_NOM_B1], mr1_r[MR1_NOM_B0]};
  assign wr_bits  = {mr2_r[MR2_WR_HI], mr2_r[MR2_WR_LO]};

  assign odt_enabled = (nom_bits != 3'h0) || (wr_bits != 2'h0);

  assign dyn_enabled = (wr_bits != 2'h0);

  assign odtl = dotc_odtl(mr0_r, mr1_r, mr2_r);

  // ***********************************************
  // Power state
  // ***********************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pd_r   <= 1'b0;
      sref_r <= 1'b0;
    end else begin
      pd_r   <= ~LINK.cke & BANKS_IDLE_I & ~LINK.sref;
      sref_r <= LINK.sref;
    end
  end

  assign dll_frozen = pd_r & ~mr0_r[MR0_DLL_PPD_BIT] & ~mr1_r[MR1_DLL_DIS_BIT];

  assign async_mode = dll_frozen;

  // ***********************************************
  // Latency pipes
  // ***********************************************
  // Sampled pin history
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      odt_pipe_r <= '0;
      wr_pipe_r  <= '0;
      bc4_pipe_r <= '0;
    end else begin
      odt_pipe_r <= {odt_pipe_r[PIPE_DEPTH-2:0], LINK.odt};
      wr_pipe_r  <= {wr_pipe_r[PIPE_DEPTH-2:0], LINK.wr & LINK.cke};
      bc4_pipe_r <= {bc4_pipe_r[PIPE_DEPTH-2:0], LINK.bc4};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      odt_async_r <= '0;
    end else begin
      odt_async_r <= ASYNC_CYC'({odt_async_r, LINK.odt});
    end
  end

  assign odt_sync_tap = odt_pipe_r[odtl - 5'h01];
  assign wr_tap       = wr_pipe_r[odtl - 5'h01];
  assign bc4_tap      = bc4_pipe_r[odtl - 5'h01];

  assign rtt_raw = async_mode ? odt_async_r[ASYNC_CYC-1] : odt_sync_tap;

  // ***********************************************
  // Termination enable
  // ***********************************************
  // Pin and fields gate
  assign rtt_en_nxt = rtt_raw & odt_enabled & ~sref_r & ~LINK.sref & ~DQ_DRIVE_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RTT_EN_O <= 1'b0;
    end else begin
      RTT_EN_O <= rtt_en_nxt;
    end
  end

  // ***********************************************
  // Dynamic strength select
  // ***********************************************
  // Load at ODTLcnw
  // Hold for 4 or 6 cycles
  always_comb begin
    wr_cnt_nxt = wr_cnt_r;
    wr_sel_nxt = 1'b0;
    if (wr_tap && dyn_enabled && !async_mode) begin
      wr_cnt_nxt = bc4_tap ? CWN4_ADD : CWN8_ADD;
      wr_sel_nxt = 1'b1;
    end else if (wr_cnt_r != 3'h0) begin
      wr_cnt_nxt = wr_cnt_r - 3'h1;
      wr_sel_nxt = (wr_cnt_r > 3'h1);
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      wr_cnt_r     <= 3'h0;
      RTT_WR_SEL_O <= 1'b0;
    end else begin
      wr_cnt_r     <= wr_cnt_nxt;
      RTT_WR_SEL_O <= wr_sel_nxt & dyn_enabled;
    end
  end

  // ***********************************************
  // Strength and mode outputs
  // ***********************************************
  // Registered strength codes
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RTT_NOM_O    <= 3'h0;
      RTT_WR_O     <= 2'h0;
      ASYNC_MODE_O <= 1'b0;
    end else begin
      RTT_NOM_O    <= nom_bits;
      RTT_WR_O     <= wr_bits;
      ASYNC_MODE_O <= async_mode;
    end
  end

endmodule

// ---- pkg/dotc_pkg.sv ----
package dotc_pkg;

  // ***********************************************
  // Mode register selects
  // ***********************************************
  localparam logic [1:0] MR0_SEL = 2'h0;
  localparam logic [1:0] MR1_SEL = 2'h1;
  localparam logic [1:0] MR2_SEL = 2'h2;

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int MR0_DLL_PPD_BIT = 12;
  localparam int MR0_CL_LO       = 4;
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int MR1_AL_LO       = 3;
  localparam int MR1_NOM_B0      = 2;
  localparam int MR1_NOM_B1      = 6;
  localparam int MR1_NOM_B2      = 9;
  localparam int MR2_CWL_LO      = 3;
  localparam int MR2_WR_LO       = 9;
  localparam int MR2_WR_HI       = 10;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [15:0] MR_RST = 16'h0000;

  // ***********************************************
  // Latencies in clock cycles
  // ***********************************************
  localparam logic [4:0] CL_BASE   = 5'h04;
  localparam logic [4:0] CWL_BASE  = 5'h05;
  localparam logic [4:0] ODTL_SUB  = 5'h02;
  localparam logic [2:0] ODTH4     = 3'h4;
  localparam logic [2:0] ODTH8     = 3'h6;
  localparam logic [2:0] CWN4_ADD  = 3'h4;
  localparam logic [2:0] CWN8_ADD  = 3'h6;
  localparam int         PIPE_DEPTH = 32;
  localparam logic [5:0] RD_QUIET   = 6'h20;

  // ***********************************************
  // Asynchronous power-down delay
  // ***********************************************
  localparam real TAONPD_MAX_NS = 8.5;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam int  ASYNC_CYC_RAW = int'($floor(TAONPD_MAX_NS / CLK_PERIOD_NS));
  localparam int  ASYNC_CYC     = (ASYNC_CYC_RAW < 1) ? 1 : ASYNC_CYC_RAW;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'h1,
    CTL_QUIET = 3'h2,
    CTL_READ = 3'h4
  } dotc_rd_state_t;

  // Write latency minus two from mode registers
  function automatic logic [4:0] dotc_odtl(input logic [15:0] mr0,
                                           input logic [15:0] mr1,
                                           input logic [15:0] mr2);
    logic [4:0] cl;
    logic [4:0] cwl;
    logic [4:0] al;
    cl  = CL_BASE + {2'h0, mr0[MR0_CL_LO +: 3]};
    cwl = CWL_BASE + {2'h0, mr2[MR2_CWL_LO +: 3]};
    case (mr1[MR1_AL_LO +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    return cwl + al - ODTL_SUB;
  endfunction

endpackage

// ---- pkg/dotc_if.sv ----
`timescale 1ns/1ps
interface dotc_if;
  logic        odt;
  logic        wr;
  logic        bc4;
  logic        rd;
  logic        mrs;
  logic [1:0]  mr_sel;
  logic [15:0] mr_data;
  logic        cke;
  logic        sref;

  modport ctl (output odt, wr, bc4, rd, mrs, mr_sel, mr_data, cke, sref);
  modport dev (input odt, wr, bc4, rd, mrs, mr_sel, mr_data, cke, sref);
endinterface

// ---- hdl/dotc_ctl.sv ----
`timescale 1ns/1ps
module dotc_ctl
  import dotc_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  dotc_if.ctl              LINK,
  input  wire logic        ODT_REQ_I,
  input  wire logic        WR_REQ_I,
  input  wire logic        WR_BC4_I,
  input  wire logic        RD_REQ_I,
  input  wire logic        MRS_REQ_I,
  input  wire logic [1:0]  MR_SEL_I,
  input  wire logic [15:0] MR_DATA_I,
  input  wire logic        CKE_I,
  input  wire logic        SREF_I,
  input  wire logic        DLL_OFF_I,
  output logic             RD_DONE_O
);

  // ***********************************************
  // Declarations
  // ***********************************************
  logic           odt_r;
  logic [2:0]     hold_r;
  logic [5:0]     quiet_r;
  dotc_rd_state_t state_r;
  logic           odt_want;
  logic [2:0]     wr_hold;

  assign wr_hold = WR_BC4_I ? ODTH4 : ODTH8;

  assign odt_want = ODT_REQ_I & ~DLL_OFF_I & ~SREF_I & (state_r == CTL_IDLE) & ~RD_REQ_I;

  // ***********************************************
  // ODT pin and hold
  // ***********************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      odt_r  <= 1'b0;
      hold_r <= 3'h0;
    end else begin
      if (!odt_r && odt_want) begin
        odt_r  <= 1'b1;
        hold_r <= ODTH4 - 3'h1;
      end else if (odt_r && WR_REQ_I) begin
        hold_r <= (wr_hold - 3'h1 > hold_r) ? wr_hold - 3'h1 : hold_r;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end else if (odt_r && !odt_want) begin
        odt_r <= 1'b0;
      end
    end
  end

  // ***********************************************
  // Read sequencing
  // ***********************************************
  // Quiet window around read
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_r   <= CTL_IDLE;
      quiet_r   <= 6'h00;
      RD_DONE_O <= 1'b0;
      LINK.rd   <= 1'b0;
    end else begin
      RD_DONE_O <= 1'b0;
      LINK.rd   <= 1'b0;
      case (state_r)
        CTL_IDLE: begin
          if (RD_REQ_I) begin
            state_r <= CTL_QUIET;
            quiet_r <= RD_QUIET;
          end
        end
        CTL_QUIET: begin
          if (odt_r) begin
            quiet_r <= RD_QUIET;
          end else if (quiet_r != 6'h00) begin
            quiet_r <= quiet_r - 6'h01;
          end else begin
            LINK.rd <= 1'b1;
            quiet_r <= RD_QUIET;
            state_r <= CTL_READ;
          end
        end
        CTL_READ: begin
          if (quiet_r != 6'h00) begin
            quiet_r <= quiet_r - 6'h01;
          end else begin
            RD_DONE_O <= 1'b1;
            state_r   <= CTL_IDLE;
          end
        end
        default: state_r <= CTL_IDLE;
      endcase
    end
  end

  // ***********************************************
  // Command outputs
  // ***********************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      LINK.odt     <= 1'b0;
      LINK.wr      <= 1'b0;
      LINK.bc4     <= 1'b0;
      LINK.mrs     <= 1'b0;
      LINK.mr_sel  <= 2'h0;
      LINK.mr_data <= MR_RST;
      LINK.cke     <= 1'b0;
      LINK.sref    <= 1'b0;
    end else begin
      LINK.odt     <= odt_r;
      LINK.wr      <= WR_REQ_I;
      LINK.bc4     <= WR_BC4_I;
      LINK.mrs     <= MRS_REQ_I;
      LINK.mr_sel  <= MR_SEL_I;
      LINK.mr_data <= MR_DATA_I;
      if (DLL_OFF_I && MR_SEL_I == MR2_SEL) begin
        LINK.mr_data[MR2_WR_HI] <= 1'b0;
        LINK.mr_data[MR2_WR_LO] <= 1'b0;
      end
      LINK.cke     <= CKE_I & ~SREF_I;
      LINK.sref    <= SREF_I;
    end
  end

endmodule

// ---- bench/dotc_asserts.sv ----
`timescale 1ns/1ps
module dotc_asserts (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic odt,
  input wire logic wr,
  input wire logic bc4,
  input wire logic rd,
  input wire logic cke,
  input wire logic sref,
  input wire logic DQ_DRIVE_I,
  input wire logic RTT_EN_O,
  input wire logic RTT_WR_SEL_O,
  input wire logic ASYNC_MODE_O
);
  // ********
  // Checks
  // ********
  logic [5:0] low_cnt_r;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || odt) begin
      low_cnt_r <= 6'h00;
    end else if (low_cnt_r != 6'h3f) begin
      low_cnt_r <= low_cnt_r + 6'h01;
    end
  end
  chk_off_low: assert property (low_cnt_r >= 6'h22 |-> !RTT_EN_O)
    else $error("termination on while odt low");
  chk_odt_hold: assert property ($rose(odt) |-> odt[*4])
    else $error("odt high under four cycles");
  chk_wr_hold_bc4: assert property (wr && odt && bc4 |-> odt[*4])
    else $error("odt dropped after chop write");
  chk_wr_hold_bl8: assert property (wr && odt && !bc4 |-> odt[*6])
    else $error("odt dropped after burst write");
  chk_rd_quiet: assert property (rd |-> (!odt && !RTT_EN_O)[*8])
    else $error("termination near read");
  chk_dq_gate: assert property (DQ_DRIVE_I |=> !RTT_EN_O)
    else $error("termination while driving");
  chk_sref_off: assert property (sref |=> !RTT_EN_O)
    else $error("termination in self refresh");
  chk_wr_sel_span: assert property ($rose(RTT_WR_SEL_O) |-> RTT_WR_SEL_O[*4])
    else $error("write strength too short");
  chk_async_pd: assert property (ASYNC_MODE_O |-> !$past(cke) || !$past(cke, 2))
    else $error("async mode with clock enabled");
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  // ********
  // Bench
  // ********
  logic        sys_clk, rst, odt_req, wr_req, wr_bc4, rd_req, mrs_req, cke, sref, dll_off;
  logic        banks_idle, dq_drive, rtt_en, rtt_wr_sel, async_mode, rd_done;
  logic [1:0]  mr_sel, rtt_wr;
  logic [2:0]  rtt_nom;
  logic [15:0] mr_data;
  int          n_errors, checked, cyc;

  dotc_if dotc_if_i ();
  dotc_ctl dotc_ctl_i (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .LINK(dotc_if_i), .ODT_REQ_I(odt_req),
    .WR_REQ_I(wr_req), .WR_BC4_I(wr_bc4), .RD_REQ_I(rd_req), .MRS_REQ_I(mrs_req),
    .MR_SEL_I(mr_sel), .MR_DATA_I(mr_data), .CKE_I(cke), .SREF_I(sref),
    .DLL_OFF_I(dll_off), .RD_DONE_O(rd_done)
  );
  dotc_dev dotc_dev_i (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .LINK(dotc_if_i), .BANKS_IDLE_I(banks_idle),
    .DQ_DRIVE_I(dq_drive), .RTT_EN_O(rtt_en), .RTT_WR_SEL_O(rtt_wr_sel),
    .RTT_NOM_O(rtt_nom), .RTT_WR_O(rtt_wr), .ASYNC_MODE_O(async_mode)
  );
  dotc_asserts dotc_asserts_i (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .odt(dotc_if_i.odt), .wr(dotc_if_i.wr),
    .bc4(dotc_if_i.bc4), .rd(dotc_if_i.rd), .cke(dotc_if_i.cke), .sref(dotc_if_i.sref),
    .DQ_DRIVE_I(dq_drive), .RTT_EN_O(rtt_en), .RTT_WR_SEL_O(rtt_wr_sel),
    .ASYNC_MODE_O(async_mode)
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      $display("ERROR %0t: run too long", $time);
      final_report();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic mrs(input logic [1:0] sel, input logic [15:0] data);
    mr_sel = sel;
    mr_data = data;
    mrs_req = 1'b1;
    step(1);
    mrs_req = 1'b0;
    step(3);
  endtask

  task automatic setmr(input logic [15:0] m0, input logic [15:0] m1, input logic [15:0] m2);
    mrs(2'h0, m0);
    mrs(2'h1, m1);
    mrs(2'h2, m2);
  endtask

  task automatic t_off(input logic prog);
    if (prog) setmr(16'h0000, 16'h0000, 16'h0000);
    odt_req = 1'b1;
    step(12);
    check(rtt_en, 1'b0);
    odt_req = 1'b0;
    step(6);
    $display("test off done");
  endtask

  task automatic t_latency(input logic [15:0] m1, input logic [15:0] m2, input int l);
    setmr(16'h0000, m1, m2);
    odt_req = 1'b1;
    step(l + 2);
    check(rtt_en, 1'b0);
    step(1);
    check(rtt_en, 1'b1);
    odt_req = 1'b0;
    step(l + 2);
    check(rtt_en, 1'b1);
    step(1);
    check(rtt_en, 1'b0);
    step(8);
    $display("test latency %0d done", l);
  endtask

  task automatic t_dyn(input logic [1:0] wsel, input logic bc4);
    setmr(16'h0000, 16'h0004, {5'h00, wsel, 9'h000});
    odt_req = 1'b1;
    step(6);
    wr_req = 1'b1;
    wr_bc4 = bc4;
    step(1);
    wr_req = 1'b0;
    step(3);
    check(rtt_wr_sel, 1'b0);
    step(1);
    check(rtt_wr_sel, |wsel);
    step(bc4 ? 3 : 5);
    check(rtt_wr_sel, |wsel);
    step(1);
    check(rtt_wr_sel, 1'b0);
    check(rtt_en, 1'b1);
    check(rtt_nom === 3'h1 && rtt_wr === wsel, 1'b1);
    odt_req = 1'b0;
    step(8);
    $display("test dynamic %0d %0d done", wsel, bc4);
  endtask

  task automatic t_hold(input logic wr, input logic bc4, input int n);
    int cnt = 0;
    odt_req = 1'b1;
    step(1);
    wr_req = wr;
    wr_bc4 = bc4;
    repeat (14) begin
      step(1);
      cnt += int'(dotc_if_i.odt === 1'b1);
      odt_req = 1'b0;
      wr_req = 1'b0;
    end
    check(cnt >= n, 1'b1);
    step(8);
    $display("test hold %0d done", n);
  endtask

  task automatic t_read();
    logic done = 1'b0;
    logic bad = 1'b0;
    odt_req = 1'b1;
    step(8);
    rd_req = 1'b1;
    step(1);
    rd_req = 1'b0;
    for (int k = 0; k < 200 && !done; k++) begin
      step(1);
      done = (rd_done === 1'b1);
      if (dotc_if_i.rd === 1'b1) bad = bad | rtt_en | dotc_if_i.odt;
    end
    check(done, 1'b1);
    check(bad, 1'b0);
    odt_req = 1'b0;
    step(8);
    $display("test read done");
  endtask

  task automatic t_gate(input logic use_sref);
    odt_req = 1'b1;
    step(8);
    dq_drive = !use_sref;
    sref = use_sref;
    step(3);
    check(rtt_en, 1'b0);
    dq_drive = 1'b0;
    sref = 1'b0;
    step(8);
    check(rtt_en, 1'b1);
    odt_req = 1'b0;
    step(8);
    $display("test gate %0d done", use_sref);
  endtask

  task automatic t_async(input logic [15:0] m0, input logic [15:0] m1, input logic exp);
    setmr(m0, m1, 16'h0200);
    banks_idle = 1'b1;
    cke = 1'b0;
    step(4);
    check(async_mode, exp);
    odt_req = 1'b1;
    step(4);
    check(rtt_en, exp);
    odt_req = 1'b0;
    step(12);
    cke = 1'b1;
    banks_idle = 1'b0;
    step(4);
    $display("test async %0d done", exp);
  endtask

  task automatic t_dll();
    int cnt = 0;
    dll_off = 1'b1;
    odt_req = 1'b1;
    repeat (10) begin
      step(1);
      cnt += int'(dotc_if_i.odt === 1'b1);
    end
    check(cnt == 0, 1'b1);
    mr_sel = 2'h2;
    mr_data = 16'h0600;
    mrs_req = 1'b1;
    step(1);
    mrs_req = 1'b0;
    check(dotc_if_i.mrs === 1'b1 && dotc_if_i.mr_data[10:9] === 2'h0, 1'b1);
    odt_req = 1'b0;
    dll_off = 1'b0;
    step(6);
    $display("test dll off done");
  endtask

  initial begin
    {sys_clk, odt_req, wr_req, wr_bc4, rd_req, mrs_req, sref, dll_off} = 8'h00;
    {banks_idle, dq_drive, mr_sel, mr_data} = 20'h00000;
    {rst, cke} = 2'h3;
    {n_errors, checked, cyc} = '0;
    step(8);
    rst = 1'b0;
    t_off(1'b0);
    t_off(1'b1);
    t_latency(16'h0004, 16'h0200, 3);
    t_latency(16'h000c, 16'h0200, 6);
    t_latency(16'h0014, 16'h0200, 5);
    for (int i = 0; i < 8; i++) t_dyn(i[2:1], i[0]);
    t_hold(1'b0, 1'b0, 4);
    t_hold(1'b1, 1'b1, 4);
    t_hold(1'b1, 1'b0, 6);
    t_read();
    t_gate(1'b0);
    t_gate(1'b1);
    t_async(16'h0000, 16'h000c, 1'b1);
    t_async(16'h1000, 16'h000c, 1'b0);
    t_async(16'h0000, 16'h000d, 1'b0);
    t_dll();
    rst = 1'b1;
    step(8);
    rst = 1'b0;
    t_off(1'b0);
    final_report();
  end
endmodule
